// ### src/nls_defines.svh
// timing counts, register offsets and field positions for the node loss supervisor
// assumes a 20 MHz core clock and a 32-bit AHB-Lite register bus
`ifndef NLS_DEFINES_SVH
`define NLS_DEFINES_SVH

// time base
`define NLS_CLK_KHZ 20000
`define NLS_LOSS_MS 2500
`define NLS_IGN_SETTLE_MS 1500
`define NLS_MSG_GAP_MS 100
`define NLS_LOSS_CYC (`NLS_LOSS_MS * `NLS_CLK_KHZ)
`define NLS_IGN_SETTLE_CYC (`NLS_IGN_SETTLE_MS * `NLS_CLK_KHZ)
`define NLS_MSG_GAP_CYC (`NLS_MSG_GAP_MS * `NLS_CLK_KHZ)

// register byte offsets
`define NLS_CTRL_OFS 8'h00
`define NLS_STATUS_OFS 8'h04
`define NLS_DTC_CUR_OFS 8'h08
`define NLS_DTC_HIST_OFS 8'h0c
`define NLS_TRIP_OFS 8'h10
`define NLS_TOTAL_OFS 8'h14

// channel layout: nodes 0..6, supply open 7, low voltage 8
`define NLS_CH_VEH 0
`define NLS_CH_MOTOR 1
`define NLS_CH_ABS 2
`define NLS_CH_BATT 3
`define NLS_CH_TEL 4
`define NLS_CH_BODY 5
`define NLS_CH_STEER 6
`define NLS_CH_SUPPLY 7
`define NLS_CH_LOWV 8
`define NLS_NODES 7
`define NLS_CHANS 9

// reset values
`define NLS_CTRL_RST 1'b1

`endif

// ### src/nls_pkg.sv
// types shared by the node loss supervisor
// assumes nls_defines.svh supplies the numeric constants
package nls_pkg;
    typedef enum logic [1:0] {
        NLS_PWR_SLEEP = 2'b00,
        NLS_PWR_ACTIVE = 2'b01,
        NLS_PWR_OFF = 2'b10
    } nls_pwr_e;
    typedef logic [25:0] nls_cnt_t;
endpackage

// ### src/nls_supervisor.sv
// node loss and supply fault supervisor for an instrument cluster
// assumes one 20 MHz clock, message valid pulses per node and level supply flags
// What this block does
// - vehicle message loss freezes odometers, resumes accumulating
// - motor message absent 2.5 s sets fault
// - motor back 2.5 s clears, logs history
// - motor loss holds speed, zero after 2.5 s
// - motor back 2.5 s shows live speed
// - brake unit loss lights brake lamps, fault
// - brake unit back: clear, lamps follow status
// - battery manager loss lights cut-off, insulation lamps
// - battery loss holds voltage, then dashes
// - battery loss holds current, then dashes
// - battery loss holds charge, then dashes
// - telematics loss lights lamp, sets fault
// - telematics back: clear, lamp follows, history
// - body controller loss lights position indicator
// - body controller back: clear, indicator follows
// - steering assist loss lights lamp, fault
// - steering assist back: clear, lamp follows
// - permanent supply open 2.5 s sets fault
// - permanent supply back 2.5 s: clear, history
// - both supplies open while active: power off, clear trip
// - supply under 9 V 2.5 s: fault
// - deep droop blanks lamps, display; keeps data
// - node supervision waits 1.5 s after ignition
//
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
`include "nls_defines.svh"

module nls_supervisor #(
    parameter nls_pkg::nls_cnt_t LOSS_CYC = 26'(`NLS_LOSS_CYC),
    parameter nls_pkg::nls_cnt_t IGN_SETTLE_CYC = 26'(`NLS_IGN_SETTLE_CYC),
    parameter nls_pkg::nls_cnt_t MSG_GAP_CYC = 26'(`NLS_MSG_GAP_CYC)
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // network messages and received status
    input wire logic [6:0] msgValid,
    input wire logic [15:0] motorSpeed,
    input wire logic [15:0] packVolt,
    input wire logic [15:0] packCurr,
    input wire logic [7:0] packSoc,
    input wire logic distPulse,
    input wire logic absFaultSts,
    input wire logic brakeFaultSts,
    input wire logic battCutSts,
    input wire logic insulSts,
    input wire logic telFaultSts,
    input wire logic posLampSts,
    input wire logic steerFaultSts,
    // supply monitors
    input wire logic ignitionOn,
    input wire logic permanentOn,
    input wire logic ignLow,
    input wire logic permLow,
    input wire logic deepDroop,
    // lamps and displays
    output logic absLamp,
    output logic brakeLamp,
    output logic battCutLamp,
    output logic insulLamp,
    output logic telLamp,
    output logic posLamp,
    output logic steerLamp,
    output logic displayOn,
    output logic deviceRun,
    output logic [15:0] speedShown,
    output logic [15:0] voltShown,
    output logic voltDash,
    output logic [15:0] currShown,
    output logic currDash,
    output logic [7:0] socShown,
    output logic socDash,
    output logic [31:0] tripDist,
    output logic [31:0] totalDist,
    output logic avgConsClear
);

    nls_pkg::nls_pwr_e pwrState;
    nls_pkg::nls_pwr_e next_pwrState;
    nls_pkg::nls_cnt_t absCnt [`NLS_CHANS];
    nls_pkg::nls_cnt_t presCnt [`NLS_CHANS];
    nls_pkg::nls_cnt_t ignCnt;
    logic [8:0] curDtc;
    logic [8:0] histDtc;
    logic [8:0] chanOk;
    logic [8:0] chanRun;
    logic [8:0] clearEv;
    logic superviseEn;
    logic droopHold;
    logic wrPend;
    logic [7:0] wrAddr;

    // bus decode
    wire busTake = hsel && htrans[1] && hready;
    wire [7:0] rdAddr = haddr[7:0];
    wire [31:0] rdMux =
        (rdAddr == `NLS_CTRL_OFS) ? {31'h0, superviseEn} :
        (rdAddr == `NLS_STATUS_OFS) ? {22'h0, pwrState, 1'b0, curDtc[6:0]} :
        (rdAddr == `NLS_DTC_CUR_OFS) ? {23'h0, curDtc} :
        (rdAddr == `NLS_DTC_HIST_OFS) ? {23'h0, histDtc} :
        (rdAddr == `NLS_TRIP_OFS) ? tripDist :
        (rdAddr == `NLS_TOTAL_OFS) ? totalDist : 32'h00000000;
    wire histWr = wrPend && (wrAddr == `NLS_DTC_HIST_OFS);
    wire ctrlWr = wrPend && (wrAddr == `NLS_CTRL_OFS);
    // power state decode
    wire bothOpen = !ignitionOn && !permanentOn;
    wire isActive = (pwrState == nls_pkg::NLS_PWR_ACTIVE);
    wire isOff = (pwrState == nls_pkg::NLS_PWR_OFF);
    wire ignSettled = isActive && (ignCnt == IGN_SETTLE_CYC);
    wire blank = droopHold || deepDroop || isOff;
    wire anyLow = ignLow || permLow;
    // power state machine
    always_comb
    begin
        next_pwrState = pwrState;
        case (pwrState)
            nls_pkg::NLS_PWR_SLEEP:
                if (ignitionOn)
                    next_pwrState = nls_pkg::NLS_PWR_ACTIVE;
            nls_pkg::NLS_PWR_ACTIVE:
                if (bothOpen)
                    next_pwrState = nls_pkg::NLS_PWR_OFF;
                else if (!ignitionOn)
                    next_pwrState = nls_pkg::NLS_PWR_SLEEP;
            nls_pkg::NLS_PWR_OFF:
                if (permanentOn)
                    next_pwrState = nls_pkg::NLS_PWR_SLEEP;
            default:
                next_pwrState = nls_pkg::NLS_PWR_SLEEP;
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            pwrState <= nls_pkg::NLS_PWR_SLEEP;
        else
            pwrState <= next_pwrState;
    end
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            ignCnt <= 26'h0000000;
        else if (!isActive || !ignitionOn)
            ignCnt <= 26'h0000000;
        else if (ignCnt != IGN_SETTLE_CYC)
            ignCnt <= ignCnt + 26'h0000001;
    end
    // channel good and run conditions
    assign chanOk = {!anyLow, permanentOn, msgValid};
    assign chanRun = {!isOff, isActive, {7{ignSettled && superviseEn}}};
    // per-channel absence and presence qualification
    genvar ch;
    generate
        for (ch = 0; ch < `NLS_CHANS; ch++)
        begin : g_chan
            always_ff @(posedge core_clk or posedge sys_rst)
            begin
                if (sys_rst)
                    absCnt[ch] <= 26'h0000000;
                else if (!chanRun[ch] || chanOk[ch])
                    absCnt[ch] <= 26'h0000000;
                else if (absCnt[ch] != LOSS_CYC)
                    absCnt[ch] <= absCnt[ch] + 26'h0000001;
            end
            // presence restarts on a miss; a supply on any bad cycle
            always_ff @(posedge core_clk or posedge sys_rst)
            begin
                if (sys_rst)
                    presCnt[ch] <= 26'h0000000;
                else if (!chanRun[ch] || absCnt[ch] > ((ch < `NLS_NODES) ? MSG_GAP_CYC : 26'h0))
                    presCnt[ch] <= 26'h0000000;
                else if (presCnt[ch] != LOSS_CYC)
                    presCnt[ch] <= presCnt[ch] + 26'h0000001;
            end
            assign clearEv[ch] = chanRun[ch] && curDtc[ch] && presCnt[ch] == LOSS_CYC;
            always_ff @(posedge core_clk or posedge sys_rst)
            begin
                if (sys_rst)
                    curDtc[ch] <= 1'b0;
                else if (chanRun[ch] && absCnt[ch] == LOSS_CYC)
                    curDtc[ch] <= 1'b1;
                else if (clearEv[ch])
                    curDtc[ch] <= 1'b0;
            end
            // recovery logs history; set beats clear
            always_ff @(posedge core_clk or posedge sys_rst)
            begin
                if (sys_rst)
                    histDtc[ch] <= 1'b0;
                else if (clearEv[ch])
                    histDtc[ch] <= 1'b1;
                else if (histWr && hwdata[ch])
                    histDtc[ch] <= 1'b0;
            end
        end
    endgenerate
    // droop blanking held until above 9 V
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            droopHold <= 1'b0;
        else if (deepDroop)
            droopHold <= 1'b1;
        else if (!anyLow)
            droopHold <= 1'b0;
    end
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            absLamp <= 1'b0;
            brakeLamp <= 1'b0;
            battCutLamp <= 1'b0;
            insulLamp <= 1'b0;
            telLamp <= 1'b0;
            posLamp <= 1'b0;
            steerLamp <= 1'b0;
            displayOn <= 1'b0;
            deviceRun <= 1'b0;
        end
        else
        begin
            absLamp <= !blank && (curDtc[`NLS_CH_ABS] || absFaultSts);
            brakeLamp <= !blank && (curDtc[`NLS_CH_ABS] || brakeFaultSts);
            battCutLamp <= !blank && (curDtc[`NLS_CH_BATT] || battCutSts);
            insulLamp <= !blank && (curDtc[`NLS_CH_BATT] || insulSts);
            telLamp <= !blank && (curDtc[`NLS_CH_TEL] || telFaultSts);
            posLamp <= !blank && (curDtc[`NLS_CH_BODY] || posLampSts);
            steerLamp <= !blank && (curDtc[`NLS_CH_STEER] || steerFaultSts);
            displayOn <= !blank;
            deviceRun <= !isOff;
        end
    end
    // speed holds on gaps, zero when lost
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            speedShown <= 16'h0000;
        else if (curDtc[`NLS_CH_MOTOR])
            speedShown <= 16'h0000;
        else if (msgValid[`NLS_CH_MOTOR])
            speedShown <= motorSpeed;
    end
    // battery values hold, dash when lost
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            voltShown <= 16'h0000;
            currShown <= 16'h0000;
            socShown <= 8'h00;
            voltDash <= 1'b0;
            currDash <= 1'b0;
            socDash <= 1'b0;
        end
        else
        begin
            if (msgValid[`NLS_CH_BATT] && !curDtc[`NLS_CH_BATT])
            begin
                voltShown <= packVolt;
                currShown <= packCurr;
                socShown <= packSoc;
            end
            voltDash <= curDtc[`NLS_CH_BATT];
            currDash <= curDtc[`NLS_CH_BATT];
            socDash <= curDtc[`NLS_CH_BATT];
        end
    end
    // odometers freeze on loss until a message returns, trip clears at power off
    wire odoFrozen = curDtc[`NLS_CH_VEH] && (absCnt[`NLS_CH_VEH] > MSG_GAP_CYC);
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tripDist <= 32'h00000000;
            totalDist <= 32'h00000000;
            avgConsClear <= 1'b0;
        end
        else
        begin
            avgConsClear <= isActive && bothOpen;
            if (isActive && bothOpen)
                tripDist <= 32'h00000000;
            else if (isActive && distPulse && !odoFrozen)
            begin
                tripDist <= tripDist + 32'h00000001;
                totalDist <= totalDist + 32'h00000001;
            end
        end
    end
    // ahb-lite slave: zero wait, always okay
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
            wrPend <= 1'b0;
            wrAddr <= 8'h00;
            superviseEn <= `NLS_CTRL_RST;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wrPend <= busTake && hwrite;
            wrAddr <= rdAddr;
            if (busTake && !hwrite)
                hrdata <= rdMux;
            if (ctrlWr)
                superviseEn <= hwdata[0];
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence motorLostSeq;
        chanRun[`NLS_CH_MOTOR] && absCnt[`NLS_CH_MOTOR] == LOSS_CYC;
    endsequence

    motor_loss_a: assert property (motorLostSeq |=> curDtc[`NLS_CH_MOTOR])
        else $error("motor loss not recorded");
    motor_hist_a: assert property ($fell(curDtc[`NLS_CH_MOTOR]) |-> histDtc[`NLS_CH_MOTOR])
        else $error("motor recovery not logged");
    speed_zero_a: assert property (motorLostSeq |=> ##1 speedShown == 16'h0000)
        else $error("speed not zero after loss");
    abs_lamps_a: assert property (curDtc[`NLS_CH_ABS] && !blank |=> absLamp && brakeLamp)
        else $error("brake lamps not lit on loss");
    batt_dash_a: assert property (curDtc[`NLS_CH_BATT] |=> voltDash && currDash && socDash)
        else $error("battery dashes missing");
    odo_freeze_a: assert property (curDtc[`NLS_CH_VEH] && absCnt[`NLS_CH_VEH] > MSG_GAP_CYC
        && !bothOpen |=> $stable(tripDist))
        else $error("odometer moved while lost");
    supply_open_a: assert property (isActive && absCnt[`NLS_CH_SUPPLY] == LOSS_CYC
        |=> curDtc[`NLS_CH_SUPPLY])
        else $error("supply open not recorded");
    power_off_a: assert property (isActive && bothOpen
        |=> isOff && tripDist == 32'h00000000 && avgConsClear ##1 !deviceRun)
        else $error("power off sequence wrong");
    droop_blank_a: assert property (deepDroop |=> !displayOn && !absLamp && !steerLamp)
        else $error("droop did not blank");
    ign_settle_a: assert property (ignCnt != IGN_SETTLE_CYC |-> chanRun[6:0] == 7'h00)
        else $error("nodes supervised before settle");

endmodule

// ### bench/nls_net_model.sv
// far side model: the other control units, each sending a periodic message
// assumes the supervisor's clock and a mute mask given by the bench
`timescale 1ns/1ns

module nls_net_model #(
    parameter int PERIOD = 3
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // bench control and live values
    input wire logic [6:0] muteMask,
    input wire logic [15:0] speedIn,
    input wire logic [15:0] voltIn,
    input wire logic [15:0] currIn,
    input wire logic [7:0] socIn,
    // messages toward the supervisor
    output logic [6:0] msgValid,
    output logic [15:0] motorSpeed,
    output logic [15:0] packVolt,
    output logic [15:0] packCurr,
    output logic [7:0] packSoc
);
    int cnt;
    logic sendMot;
    logic sendBat;

    // payload only valid with its message pulse
    assign sendMot = (cnt == 0) && !muteMask[1];
    assign sendBat = (cnt == 0) && !muteMask[3];

    // each unmuted node sends once per period
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt <= 0;
            msgValid <= 7'h00;
        end
        else
        begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            msgValid <= (cnt == 0) ? ~muteMask : 7'h00;
        end
    end

    // between messages the payload is inverted so stale sampling shows up
    always_ff @(posedge core_clk)
    begin
        motorSpeed <= sendMot ? speedIn : ~speedIn;
        packVolt <= sendBat ? voltIn : ~voltIn;
        packCurr <= sendBat ? currIn : ~currIn;
        packSoc <= sendBat ? socIn : ~socIn;
    end
endmodule

// ### bench/nls_supervisor_tb_top.sv
// self-checking bench for the node loss supervisor
// assumes shortened loss and settle counts and an ahb-lite master made here
`timescale 1ns/1ns
`include "nls_defines.svh"

module nls_supervisor_tb_top;
    localparam int LOSS = 40;
    localparam logic [31:0] ASTAT = 32'(`NLS_STATUS_OFS);
    localparam logic [31:0] ACUR = 32'(`NLS_DTC_CUR_OFS);
    localparam logic [31:0] AHIST = 32'(`NLS_DTC_HIST_OFS);
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [31:0] haddr = '0, hwdata = '0, rd, obsVal, expHead;
    logic [6:0] muteMask = 7'h7f, sts = '0;
    logic [15:0] spd = '0, volt = '0, curr = '0, lastSpd;
    logic [7:0] soc = '0;
    logic distPulse = 1'b0, ignitionOn = 1'b0, permanentOn = 1'b1, ignLow = 1'b0;
    logic permLow = 1'b0, deepDroop = 1'b0, obsStb = 1'b0, avgSeen = 1'b0;
    logic hreadyout, hresp, absLamp, brakeLamp, battCutLamp, insulLamp, telLamp;
    logic posLamp, steerLamp, displayOn, deviceRun, voltDash, currDash, socDash, avgConsClear;
    logic [31:0] hrdata, tripDist, totalDist;
    logic [15:0] speedShown, voltShown, currShown, motorSpeed, packVolt, packCurr;
    logic [7:0] socShown, packSoc;
    logic [6:0] msgValid, lampVec;
    logic [31:0] expQ[$];
    int err_total = 0;
    int check_count = 0;

    assign lampVec = {absLamp, brakeLamp, battCutLamp, insulLamp, telLamp, posLamp, steerLamp};

    nls_supervisor #(.LOSS_CYC(26'd40), .IGN_SETTLE_CYC(26'd10), .MSG_GAP_CYC(26'd5)) DUT (
        .core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .msgValid, .motorSpeed,
        .packVolt, .packCurr, .packSoc, .distPulse, .absFaultSts(sts[6]),
        .brakeFaultSts(sts[5]), .battCutSts(sts[4]), .insulSts(sts[3]), .telFaultSts(sts[2]),
        .posLampSts(sts[1]), .steerFaultSts(sts[0]), .ignitionOn, .permanentOn, .ignLow,
        .permLow, .deepDroop, .absLamp, .brakeLamp, .battCutLamp, .insulLamp, .telLamp,
        .posLamp, .steerLamp, .displayOn, .deviceRun, .speedShown, .voltShown, .voltDash,
        .currShown, .currDash, .socShown, .socDash, .tripDist, .totalDist, .avgConsClear);

    nls_net_model #(.PERIOD(3)) netModel (.core_clk, .sys_rst, .muteMask, .speedIn(spd),
        .voltIn(volt), .currIn(curr), .socIn(soc), .msgValid, .motorSpeed, .packVolt,
        .packCurr, .packSoc);

    // clock
    initial
    begin
        forever #25 core_clk = ~core_clk;
    end

    // result watcher: oldest note against the observed value
    always @(posedge core_clk)
    begin
        if (avgConsClear === 1'b1)
            avgSeen <= 1'b1;
        if (obsStb === 1'b1)
        begin
            expHead = expQ.pop_front();
            check_count++;
            if (obsVal !== expHead)
            begin
                err_total++;
                $display("mismatch at %0t: got %h expected %h", $time, obsVal, expHead);
            end
        end
    end

    task automatic stop_test;
        if (err_total == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // note an expectation with the value seen
    task automatic note(input logic [31:0] e, input logic [31:0] a);
        expQ.push_back(e);
        obsVal <= a;
        obsStb <= 1'b1;
        tick(1);
        obsStb <= 1'b0;
        tick(1);
    endtask

    // one ahb-lite single transfer, held until hready
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= addr;
        tick(1);
        while (hreadyout !== 1'b1) tick(1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        tick(1);
        while (hreadyout !== 1'b1) tick(1);
        rd = hrdata;
    endtask

    task automatic rdchk(input logic [31:0] addr, input logic [31:0] e);
        bus(1'b0, addr, 32'h0);
        note(e, rd);
    endtask

    task automatic pulse(input int n);
        repeat (n)
        begin
            distPulse <= 1'b1;
            tick(1);
            distPulse <= 1'b0;
            tick(1);
        end
        tick(2);
    endtask

    // watchdog
    initial
    begin
        tick(20000);
        err_total++;
        stop_test();
    end

    // main sequence
    initial
    begin
        void'($urandom(32'hc45c));
        tick(3);
        sys_rst <= 1'b0;
        tick(2);
        rdchk(32'(`NLS_CTRL_OFS), 32'(`NLS_CTRL_RST));
        note(32'h0, 32'(hresp));
        bus(1'b1, 32'h40, 32'hffffffff);
        rdchk(32'h40, 32'h0);
        sts <= 7'($urandom);
        spd <= 16'($urandom);
        volt <= 16'($urandom);
        curr <= 16'($urandom);
        soc <= 8'($urandom);
        ignitionOn <= 1'b1;
        tick(LOSS + 2);
        // settle delay then every node lost
        rdchk(ASTAT, 32'h100);
        tick(14);
        rdchk(ASTAT, 32'h17f);
        rdchk(ACUR, 32'h7f);
        note(32'h7f, 32'(lampVec));
        note(32'h7, {29'h0, voltDash, currDash, socDash});
        note(32'h0, 32'(speedShown));
        // recovery of every node
        muteMask <= 7'h00;
        tick(LOSS + 8);
        rdchk(ACUR, 32'h0);
        rdchk(AHIST, 32'h7f);
        note(32'(sts), 32'(lampVec));
        note(32'(spd), 32'(speedShown));
        note({volt, curr}, {voltShown, currShown});
        note(32'({soc, 3'h0}), 32'({socShown, voltDash, currDash, socDash}));
        bus(1'b1, AHIST, 32'h7f);
        rdchk(AHIST, 32'h0);
        // absence count restarts on each message
        repeat (2)
        begin
            muteMask <= 7'h08;
            tick(LOSS - 10);
            muteMask <= 7'h00;
            tick(5);
        end
        rdchk(ASTAT, 32'h100);
        // odometer freeze and speed hold
        pulse(3);
        note(32'd3, tripDist);
        lastSpd = spd;
        spd <= ~spd;
        muteMask <= 7'h03;
        tick(LOSS / 2);
        note(32'(lastSpd), 32'(speedShown));
        tick(LOSS / 2 + 8);
        note(32'h0, 32'(speedShown));
        rdchk(ACUR, 32'h3);
        pulse(2);
        note(32'd3, totalDist);
        muteMask <= 7'h00;
        tick(6);
        pulse(2);
        note(32'd5, tripDist);
        tick(LOSS);
        note(32'(spd), 32'(speedShown));
        rdchk(ACUR, 32'h0);
        note(32'd5, totalDist);
        // permanent supply open while awake
        permanentOn <= 1'b0;
        tick(LOSS + 6);
        rdchk(ACUR, 32'h80);
        note(32'h1, 32'(deviceRun));
        permanentOn <= 1'b1;
        tick(LOSS + 6);
        rdchk(ACUR, 32'h0);
        // low voltage on each supply
        for (int i = 0; i < 2; i++)
        begin
            {ignLow, permLow} <= (i == 0) ? 2'b10 : 2'b01;
            tick(LOSS + 6);
            rdchk(ACUR, 32'h100);
            {ignLow, permLow} <= 2'b00;
            tick(LOSS + 6);
            rdchk(ACUR, 32'h0);
        end
        rdchk(AHIST, 32'h183);
        // deep droop blanks and restores
        deepDroop <= 1'b1;
        tick(4);
        note(32'h0, 32'({displayOn, lampVec}));
        deepDroop <= 1'b0;
        tick(4);
        note(32'({1'b1, sts}), 32'({displayOn, lampVec}));
        note(32'd5, tripDist);
        // both supplies open together
        ignitionOn <= 1'b0;
        permanentOn <= 1'b0;
        tick(3);
        note(32'h0, 32'(deviceRun));
        note(32'h0, tripDist);
        note(32'h1, 32'(avgSeen));
        rdchk(ASTAT, 32'h200);
        stop_test();
    end
endmodule
